// ### verilog/sefe_defines.vh
// Constants for the serial EEPROM SPI front end
`ifndef SEFE_DEFINES_VH
`define SEFE_DEFINES_VH
`define SEFE_OP_READ_STATUS   8'h05
`define SEFE_OP_LOW_POWER_POLL 8'h08
`define SEFE_OP_SET_WRITE     8'h06
`define SEFE_OP_CLEAR_WRITE   8'h04
`define SEFE_OP_WRITE_STATUS  8'h01
`define SEFE_OP_READ_ARRAY    8'h03
`define SEFE_OP_WRITE_ARRAY_A 8'h02
`define SEFE_OP_WRITE_ARRAY_B 8'h07
`define SEFE_SR_PROTECT_BIT   7
`define SEFE_SR_LATCH_BIT     1
`define SEFE_SR_BUSY_BIT      0
`define SEFE_SR_RESET         8'h00
`define SEFE_POLL_BUSY        8'hFF
`define SEFE_POLL_IDLE        8'h00
`define SEFE_FIFO_WIDTH       8
`define SEFE_FIFO_DEPTH       32
`define SEFE_FIFO_AW          5
`endif

// ### verilog/sefe_fifo.v
// Receive FIFO now lives beside the front end so that one design file holds all the logic

// ### verilog/sefe_spi_front_end.v
// SPI slave front end of a serial EEPROM: framing, opcode decode, pause, write protect
// Contract
// - Sample input on rising, shift output falling.
// - Deselected: ignore input, output tristated.
// - MSB first; first bit at first rise.
// - Return data MSB first after opcode.
// - Start on select fall; first byte opcode.
// - Invalid opcode: ignore input until reselect.
// - Pause never suspends a running write.
// - Pause begins only selected, during clock low.
// - Paused: output off, input and clock ignored.
// - Pause ends on release at clock low.
// - Deselect while paused aborts, clears latch.
// - Protect pin low plus enable blocks status writes.
// - Protect fall cancels pending status write.
// - Enable bit zero makes protect pin ignored.
// - Opcode 05h returns status register.
// - Opcode 08h returns busy poll byte.
// - Opcode 06h sets latch, 04h clears.
// - Opcode 01h writes status register.
// - Opcode 03h reads memory array.
// - Opcodes 02h and 07h write array.
// - Write enable latch zero after reset.
// - Writes refused while latch is zero.
`timescale 1ns/1ps
`include "sefe_defines.vh"
module sefe_spi_front_end (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       chip_select_n_i,
	input  wire       serial_clock_i,
	input  wire       serial_in_i,
	input  wire       pause_n_i,
	input  wire       write_protect_n_i,
	output reg        serial_out_o,
	output reg        serial_out_en_o,
	input  wire       write_busy_i,
	output reg        write_start_o,
	output reg        array_read_o,
	output reg        array_write_o,
	output reg        array_abort_o,
	output reg [7:0]  array_addr_hi_o,
	input  wire [7:0] read_data_i,
	input  wire       read_valid_i,
	output reg        read_ready_o,
	output reg [7:0]  rx_data_o,
	output reg        rx_valid_o,
	input  wire       rx_ready_i,
	output reg        rx_overflow_o,
	output reg [7:0]  status_o,
	output reg        write_enable_latch_o
);
	localparam ST_IDLE    = 6'b000001;
	localparam ST_OPCODE  = 6'b000010;
	localparam ST_TXSTAT  = 6'b000100;
	localparam ST_TXARRAY = 6'b001000;
	localparam ST_RXDATA  = 6'b010000;
	localparam ST_DEAD    = 6'b100000;
	localparam [7:0] SR_RESET = `SEFE_SR_RESET;

	// Two-flop synchronisers; only the second stage is read by logic
	reg [1:0] cs_sync;
	reg [1:0] sck_sync;
	reg [1:0] si_sync;
	reg [1:0] hold_sync;
	reg [1:0] wp_sync;
	reg       sck_d;
	reg       cs_d;
	reg       wp_d;
	wire      cs_n   = cs_sync[1];
	wire      sck    = sck_sync[1];
	wire      si     = si_sync[1];
	wire      hold_n = hold_sync[1];
	wire      wp_n   = wp_sync[1];

	reg [5:0] state;
	reg [7:0] shift_in;
	reg [2:0] bit_cnt;
	reg [7:0] shift_out;
	reg       paused;
	reg       status_wr;
	reg [7:0] opcode;
	reg       fifo_in_valid;
	reg [7:0] fifo_in_data;
	reg       fifo_pop;
	reg       protect_pin_enable;
	reg [3:2] block_protect;

	wire fifo_in_ready;
	wire [7:0] fifo_out_data;
	wire fifo_out_valid;

	function is_valid_op;
		input [7:0] op;
		begin
			case (op)
				`SEFE_OP_READ_STATUS, `SEFE_OP_LOW_POWER_POLL, `SEFE_OP_SET_WRITE,
				`SEFE_OP_CLEAR_WRITE, `SEFE_OP_WRITE_STATUS, `SEFE_OP_READ_ARRAY,
				`SEFE_OP_WRITE_ARRAY_A, `SEFE_OP_WRITE_ARRAY_B:
					is_valid_op = 1'b1;
				default:
					is_valid_op = 1'b0;
			endcase
		end
	endfunction

	function [7:0] status_word;
		input       pen;
		input [3:2] bp;
		input       write_enable_latch;
		input       busy;
		begin
			status_word = {pen, {3{busy}}, bp, write_enable_latch, busy};
		end
	endfunction

	wire [7:0] status_now = status_word(protect_pin_enable, block_protect, write_enable_latch_o, write_busy_i);
	wire [7:0] poll_now   = write_busy_i ? `SEFE_POLL_BUSY : `SEFE_POLL_IDLE;
	wire       sck_rise   = sck & ~sck_d;
	wire       sck_fall   = ~sck & sck_d;
	wire       cs_fall    = ~cs_n & cs_d;
	wire       cs_rise    = cs_n & ~cs_d;
	wire       rx_bit     = sck_rise & ~paused & ~cs_n;
	wire       tx_bit     = sck_fall & ~paused & ~cs_n;
	wire [7:0] rx_byte    = {shift_in[6:0], si};
	wire       byte_done  = rx_bit & (bit_cnt == 3'h7);
	wire       protect_on = protect_pin_enable & ~wp_n;
	wire       tx_state   = (state == ST_TXSTAT) | (state == ST_TXARRAY);

	sefe_fifo #(
		.WIDTH(`SEFE_FIFO_WIDTH),
		.DEPTH(`SEFE_FIFO_DEPTH),
		.AW   (`SEFE_FIFO_AW)
	) u_rx_fifo (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.flush_i    (cs_fall),
		.in_data_i  (fifo_in_data),
		.in_valid_i (fifo_in_valid),
		.in_ready_o (fifo_in_ready),
		.out_data_o (fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop)
	);

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_sync   <= 2'h3;
			sck_sync  <= 2'h0;
			si_sync   <= 2'h0;
			hold_sync <= 2'h3;
			wp_sync   <= 2'h3;
			sck_d     <= 1'b0;
			cs_d      <= 1'b1;
			wp_d      <= 1'b1;
		end else begin
			cs_sync   <= {cs_sync[0], chip_select_n_i};
			sck_sync  <= {sck_sync[0], serial_clock_i};
			si_sync   <= {si_sync[0], serial_in_i};
			hold_sync <= {hold_sync[0], pause_n_i};
			wp_sync   <= {wp_sync[0], write_protect_n_i};
			sck_d     <= sck;
			cs_d      <= cs_n;
			wp_d      <= wp_n;
		end
	end

	// Pause enters and leaves while the serial clock is low; deselect clears it at any clock level
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			paused <= 1'b0;
		else if (cs_n)
			paused <= 1'b0;
		else if (!sck)
			paused <= ~hold_n;
	end

	// Drain receive FIFO into the output register toward the array engine
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_data_o  <= 8'h00;
			rx_valid_o <= 1'b0;
			fifo_pop   <= 1'b0;
		end else begin
			fifo_pop <= 1'b0;
			if (rx_valid_o & rx_ready_i)
				rx_valid_o <= 1'b0;
			else if (!rx_valid_o & fifo_out_valid & !fifo_pop) begin
				rx_data_o  <= fifo_out_data;
				rx_valid_o <= 1'b1;
				fifo_pop   <= 1'b1;
			end
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state                <= ST_IDLE;
			shift_in             <= 8'h00;
			bit_cnt              <= 3'h0;
			shift_out            <= 8'h00;
			opcode               <= 8'h00;
			status_wr            <= 1'b0;
			fifo_in_valid        <= 1'b0;
			fifo_in_data         <= 8'h00;
			rx_overflow_o        <= 1'b0;
			protect_pin_enable   <= SR_RESET[`SEFE_SR_PROTECT_BIT];
			block_protect        <= SR_RESET[3:2];
			read_ready_o         <= 1'b0;
			write_enable_latch_o <= 1'b0;
			write_start_o        <= 1'b0;
			array_read_o         <= 1'b0;
			array_write_o        <= 1'b0;
			array_abort_o        <= 1'b0;
			array_addr_hi_o      <= 8'h00;
			serial_out_o         <= 1'b0;
			serial_out_en_o      <= 1'b0;
			status_o             <= `SEFE_SR_RESET;
		end else begin
			fifo_in_valid <= 1'b0;
			write_start_o <= 1'b0;
			array_abort_o <= 1'b0;
			read_ready_o  <= 1'b0;
			status_o      <= status_now;
			if (cs_fall) begin
				state     <= ST_OPCODE;
				// Old opcode must not be applied again by an empty frame
				opcode    <= 8'h00;
				bit_cnt   <= 3'h0;
				shift_in  <= 8'h00;
				status_wr <= 1'b0;
				rx_overflow_o <= 1'b0;
			end else if (cs_rise) begin
				state         <= ST_IDLE;
				bit_cnt       <= 3'h0;
				array_read_o  <= 1'b0;
				array_write_o <= 1'b0;
				if (!hold_n) begin
					write_enable_latch_o <= 1'b0;
					array_abort_o        <= 1'b1;
					status_wr            <= 1'b0;
				end else if (state == ST_OPCODE && bit_cnt == 3'h0) begin
					if (opcode == `SEFE_OP_SET_WRITE)
						write_enable_latch_o <= 1'b1;
					else if (opcode == `SEFE_OP_CLEAR_WRITE)
						write_enable_latch_o <= 1'b0;
					else if (status_wr & !write_busy_i) begin
						protect_pin_enable   <= shift_in[`SEFE_SR_PROTECT_BIT];
						block_protect        <= shift_in[3:2];
						write_enable_latch_o <= 1'b0;
						write_start_o        <= 1'b1;
					end
				end else if (array_write_o) begin
					write_enable_latch_o <= 1'b0;
					write_start_o        <= 1'b1;
				end
			end else if (!cs_n) begin
				if (wp_d & ~wp_n & protect_pin_enable)
					status_wr <= 1'b0;
				if (rx_bit && state != ST_DEAD && state != ST_IDLE) begin
					shift_in <= rx_byte;
					bit_cnt  <= bit_cnt + 3'h1;
				end
				if (byte_done) begin
					case (state)
						ST_OPCODE: begin
							opcode <= rx_byte;
							if (!is_valid_op(rx_byte))
								state <= ST_DEAD;
							else if (rx_byte == `SEFE_OP_READ_STATUS) begin
								state     <= ST_TXSTAT;
								shift_out <= status_now;
							end else if (rx_byte == `SEFE_OP_LOW_POWER_POLL) begin
								state     <= ST_TXSTAT;
								shift_out <= poll_now;
							end else if (rx_byte == `SEFE_OP_READ_ARRAY) begin
								state        <= ST_RXDATA;
								array_read_o <= 1'b1;
							end else if (rx_byte == `SEFE_OP_WRITE_STATUS) begin
								state <= (write_enable_latch_o & ~protect_on) ? ST_RXDATA : ST_DEAD;
							end else if (rx_byte == `SEFE_OP_WRITE_ARRAY_A || rx_byte == `SEFE_OP_WRITE_ARRAY_B) begin
								state         <= write_enable_latch_o ? ST_RXDATA : ST_DEAD;
								array_write_o <= write_enable_latch_o;
							end
						end
						ST_RXDATA: begin
							if (opcode == `SEFE_OP_WRITE_STATUS) begin
								status_wr <= 1'b1;
								state     <= ST_OPCODE;
								bit_cnt   <= 3'h0;
							end else begin
								array_addr_hi_o <= rx_byte;
								fifo_in_data    <= rx_byte;
								fifo_in_valid   <= fifo_in_ready;
								rx_overflow_o   <= rx_overflow_o | ~fifo_in_ready;
								if (array_read_o && read_valid_i) begin
									state        <= ST_TXARRAY;
									shift_out    <= read_data_i;
									read_ready_o <= 1'b1;
								end
							end
						end
						default: begin
							// Next array byte is taken at each byte boundary while reading
							read_ready_o <= (state == ST_TXARRAY);
							shift_out <= (opcode == `SEFE_OP_LOW_POWER_POLL) ? poll_now :
								(opcode == `SEFE_OP_READ_STATUS) ? status_now : read_data_i;
						end
					endcase
				end else if (tx_bit & tx_state) begin
					serial_out_o <= shift_out[~bit_cnt];
				end
			end
			// Output driven only while selected, not paused and answering; it turns on at a falling edge
			serial_out_en_o <= ~cs_n & ~paused & tx_state & (serial_out_en_o | tx_bit);
		end
	end
endmodule

// Synchronous word FIFO with valid/ready on both sides
module sefe_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk_i,
	input  wire             rst_n_i,
	input  wire             flush_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push = in_valid_i & in_ready_o;
	wire            pop  = out_valid_o & out_ready_i;
	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	always @(posedge clk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (flush_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & !pop)
				count <= count + 1'b1;
			else if (pop & !push)
				count <= count - 1'b1;
		end
	end
endmodule

// ### verif/sefe_checker.sv
// Assertions on the SPI front end ports
`timescale 1ns/1ps
module sefe_checker (
	input wire clk_i,
	input wire rst_n_i,
	input wire chip_select_n_i,
	input wire serial_clock_i,
	input wire pause_n_i,
	input wire serial_out_o,
	input wire serial_out_en_o,
	input wire write_start_o,
	input wire array_abort_o,
	input wire write_enable_latch_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Six cycles leave room for the select synchroniser
	sequence s_idle; chip_select_n_i [*6]; endsequence
	sequence s_held; (!pause_n_i && !serial_clock_i && !chip_select_n_i) [*8]; endsequence
	property p_idle; s_idle |-> !serial_out_en_o; endproperty
	property p_held; s_held |-> !serial_out_en_o; endproperty
	property p_wel0; $rose(rst_n_i) |-> !write_enable_latch_o; endproperty
	property p_abort; array_abort_o |-> ##[0:4] !write_enable_latch_o; endproperty
	property p_abpulse; array_abort_o |=> !array_abort_o; endproperty
	property p_stpulse; write_start_o |=> !write_start_o; endproperty
	property p_stwel; write_start_o |-> chip_select_n_i && $past(write_enable_latch_o); endproperty
	property p_enlow; $rose(serial_out_en_o) |-> !serial_clock_i && !chip_select_n_i; endproperty
	property p_hold; (serial_clock_i && serial_out_en_o) [*4] |-> $stable(serial_out_o); endproperty
	a_idle: assert property (p_idle) else $error("output on while deselected");
	a_held: assert property (p_held) else $error("output on while paused");
	a_wel0: assert property (p_wel0) else $error("latch set out of reset");
	a_abort: assert property (p_abort) else $error("latch kept after abort");
	a_abpulse: assert property (p_abpulse) else $error("abort too long");
	a_stpulse: assert property (p_stpulse) else $error("start too long");
	a_stwel: assert property (p_stwel) else $error("write without latch");
	a_enlow: assert property (p_enlow) else $error("output enabled off low phase");
	a_hold: assert property (p_hold) else $error("output moved in high phase");
endmodule
bind sefe_spi_front_end sefe_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i), .pause_n_i(pause_n_i),
	.serial_out_o(serial_out_o), .serial_out_en_o(serial_out_en_o), .write_start_o(write_start_o),
	.array_abort_o(array_abort_o), .write_enable_latch_o(write_enable_latch_o));

// ### verif/sefe_spi_master.sv
// Behavioural SPI master driving the link in mode 0 or 3
`timescale 1ns/1ps
module sefe_spi_master (
	input  wire serial_out_i,
	input  wire serial_out_en_i,
	output reg  chip_select_n_o,
	output reg  serial_clock_o,
	output reg  serial_in_o
);
	localparam real HALF = 62.5;
	reg mode3;
	initial begin
		mode3 = 1'b0;
		chip_select_n_o = 1'b1;
		serial_clock_o = 1'b0;
		serial_in_o = 1'b0;
	end
	task open_frame;
	begin
		serial_clock_o = mode3;
		#(HALF);
		chip_select_n_o = 1'b0;
		#(HALF);
	end
	endtask
	task shift(input [7:0] tx, output [7:0] rx);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1) begin
			serial_clock_o = 1'b0;
			serial_in_o = tx[i];
			#(HALF);
			serial_clock_o = 1'b1;
			rx[i] = serial_out_en_i ? serial_out_i : 1'bx;
			#(HALF);
		end
	end
	endtask
	task close_frame;
	begin
		serial_clock_o = mode3;
		#(HALF * 2);
		chip_select_n_o = 1'b1;
		// Released data line must not keep its last level
		serial_in_o = ~serial_in_o;
		#(HALF * 4);
	end
	endtask
endmodule

// ### verif/sefe_spi_front_end_bench.sv
// Self-checking bench for the SPI front end
`timescale 1ns/1ps
`include "sefe_defines.vh"
module sefe_spi_front_end_bench;
	reg        clk_i;
	reg        rst_n_i;
	reg        pause_n;
	reg        wp_n;
	reg        busy;
	reg        rx_ready;
	reg  [7:0] got;
	integer    errors;
	integer    total_checks;
	integer    n;
	integer    k;
	wire       cs_n, sck, mosi, so, so_en, ard, awr, rx_valid, rx_ovf, write_enable_latch;
	wire [7:0] rx_data;
	wire [7:0] status;
	sefe_spi_front_end u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
		.serial_clock_i(sck), .serial_in_i(mosi), .pause_n_i(pause_n), .write_protect_n_i(wp_n),
		.serial_out_o(so), .serial_out_en_o(so_en), .write_busy_i(busy), .write_start_o(),
		.array_read_o(ard), .array_write_o(awr), .array_abort_o(), .array_addr_hi_o(),
		.read_data_i(8'h5A), .read_valid_i(1'b1), .read_ready_o(), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_overflow_o(rx_ovf), .status_o(status),
		.write_enable_latch_o(write_enable_latch));
	sefe_spi_master u_mst (.serial_out_i(so), .serial_out_en_i(so_en), .chip_select_n_o(cs_n),
		.serial_clock_o(sck), .serial_in_o(mosi));
	always #5 clk_i = ~clk_i;
	task check(input [255:0] what, input [7:0] exp, input [7:0] seen);
	begin
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[FAIL] %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task cmd(input [7:0] op, input [7:0] dat, input integer nd);
		integer j;
	begin
		u_mst.open_frame;
		u_mst.shift(op, got);
		for (j = 0; j < nd; j = j + 1)
			u_mst.shift(dat, got);
		u_mst.close_frame;
	end
	endtask
	task wr_status(input [7:0] v);
	begin
		cmd(`SEFE_OP_SET_WRITE, 8'h00, 0);
		cmd(`SEFE_OP_WRITE_STATUS, v, 1);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial begin
		#500000;
		errors = errors + 1;
		close_out;
	end
	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		pause_n = 1'b1;
		wp_n = 1'b1;
		busy = 1'b0;
		rx_ready = 1'b1;
		errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		check("latch", 8'h00, {7'h00, write_enable_latch});
		check("status", 8'h00, status);
		for (n = 0; n < 2; n = n + 1) begin
			u_mst.mode3 = n[0];
			cmd(`SEFE_OP_SET_WRITE, 8'h00, 0);
			check("latch", 8'h01, {7'h00, write_enable_latch});
			cmd(`SEFE_OP_READ_STATUS, 8'h00, 1);
			check("status read", 8'h02, got);
			cmd(`SEFE_OP_CLEAR_WRITE, 8'h00, 0);
			check("latch", 8'h00, {7'h00, write_enable_latch});
		end
		u_mst.mode3 = 1'b0;
		for (n = 0; n < 2; n = n + 1) begin
			@(posedge clk_i) #1 busy = ~n[0];
			cmd(`SEFE_OP_LOW_POWER_POLL, 8'h00, 1);
			check("poll", n ? 8'h00 : 8'hFF, got);
		end
		$display("modes and poll done");
		cmd(`SEFE_OP_WRITE_STATUS, 8'h80, 1);
		check("status", 8'h00, status);
		wr_status(8'h80);
		check("status", 8'h80, status);
		cmd(`SEFE_OP_SET_WRITE, 8'h00, 0);
		u_mst.open_frame;
		u_mst.shift(`SEFE_OP_WRITE_STATUS, got);
		u_mst.shift(8'h8C, got);
		@(posedge clk_i) #1 wp_n = 1'b0;
		u_mst.close_frame;
		check("status", 8'h80, status & 8'hFC);
		wr_status(8'h0C);
		check("status", 8'h80, status & 8'hFC);
		@(posedge clk_i) #1 wp_n = 1'b1;
		wr_status(8'h00);
		check("status", 8'h00, status);
		@(posedge clk_i) #1 wp_n = 1'b0;
		wr_status(8'h0C);
		check("status", 8'h0C, status);
		wr_status(8'h00);
		@(posedge clk_i) #1 wp_n = 1'b1;
		$display("protect done");
		@(posedge clk_i) #1 rx_ready = 1'b0;
		for (n = 0; n < 4; n = n + 1) begin
			cmd(8'h00 + 8'h09 * n[7:0] * n[7:0], `SEFE_OP_SET_WRITE, 1);
			check("invalid out", 8'hxx, got);
			check("invalid in", 8'h00, {6'h00, write_enable_latch, rx_valid});
		end
		u_mst.open_frame;
		u_mst.shift(`SEFE_OP_READ_ARRAY, got);
		u_mst.shift(8'h00, got);
		check("array read", 8'h01, {7'h00, ard});
		u_mst.close_frame;
		@(posedge clk_i) #1 rx_ready = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 rx_ready = 1'b0;
		for (n = 0; n < 2; n = n + 1) begin
			cmd(`SEFE_OP_SET_WRITE, 8'h00, 0);
			u_mst.open_frame;
			u_mst.shift(n ? `SEFE_OP_WRITE_ARRAY_B : `SEFE_OP_WRITE_ARRAY_A, got);
			for (k = 0; k < 1 + 32 * n; k = k + 1)
				u_mst.shift(k[7:0] ^ 8'hC3, got);
			check("array write", {6'h00, 1'b1, n[0]}, {6'h00, awr, rx_ovf});
			u_mst.close_frame;
		end
		check("first word", 8'hC3, rx_data);
		@(posedge clk_i) #1 rx_ready = 1'b1;
		n = 0;
		for (k = 0; k < 100; k = k + 1) begin
			if (rx_valid === 1'b1)
				n = n + 1;
			@(posedge clk_i) #1;
		end
		// The held output word plus a full FIFO
		check("words", 8'd33, n[7:0]);
		$display("array and fifo done");
		cmd(`SEFE_OP_SET_WRITE, 8'h00, 0);
		u_mst.open_frame;
		// Latch opcode in this frame: only the abort can leave the latch clear
		u_mst.shift(`SEFE_OP_SET_WRITE, got);
		@(posedge clk_i) #1 pause_n = 1'b0;
		u_mst.close_frame;
		check("latch", 8'h00, {7'h00, write_enable_latch});
		@(posedge clk_i) #1 pause_n = 1'b1;
		$display("pause done");
		close_out;
	end
endmodule
